// File: core/dsr_params.svh
`ifndef DSR_PARAMS_SVH
`define DSR_PARAMS_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define DSR_CLK_HZ            250000000
`define DSR_MASTER_HZ         20000000
`define DSR_MEAS_INTERVAL_S   1
`define DSR_PPM_LIMIT         12
`define DSR_SEC_NOM_HZ        8000
`define DSR_FRAME_HZ          8000
`define DSR_RATE_DIV          4
`define DSR_E3_KHZ            34368
`define DSR_T3_KHZ            44736
`define DSR_MEAS_CYCLES       (`DSR_CLK_HZ * `DSR_MEAS_INTERVAL_S)
`define DSR_FRAME_DIV         (`DSR_CLK_HZ / `DSR_FRAME_HZ)
`define DSR_RESET_OOR         1'b0
`endif

// File: core/dsr_pkg.sv
package dsr_pkg;
  typedef enum logic [1:0] {
    DSR_FREE_RUN,
    DSR_NORMAL,
    DSR_HOLDOVER
  } dsr_mode_t;
  typedef enum logic {
    DSR_REF_PRI,
    DSR_REF_SEC
  } dsr_ref_t;
endpackage

// File: core/dsr_rate_gen.sv
`include "dsr_params.svh"
module dsr_rate_gen #(
  parameter int ACC_W = 24
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic [ACC_W-1:0] i_step,
  input  wire logic             i_div4,
  output logic                  o_clk_out
);
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [1:0]       sub;
    logic             out;
  } dsr_rg_state_t;

  dsr_rg_state_t st_r;
  dsr_rg_state_t st_nxt;
  logic [ACC_W:0] sum;

  if (ACC_W < 8) begin : g_bad_acc_w
    $error("dsr_rate_gen: ACC_W too small");
  end

  always_comb begin
    st_nxt = st_r;
    sum    = {1'b0, st_r.acc} + {1'b0, i_step};
    st_nxt.acc = sum[ACC_W-1:0];
    if (sum[ACC_W]) begin
      st_nxt.sub = st_r.sub + 2'h1;
      if (!i_div4 || (st_r.sub == 2'h3)) begin
        st_nxt.out = ~st_r.out;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_clk_out = st_r.out;
endmodule // dsr_rate_gen

// File: core/dsr_status.sv
`include "dsr_params.svh"
module dsr_status #(
  parameter int MEAS_CYCLES = `DSR_MEAS_CYCLES,
  parameter int FRAME_DIV   = `DSR_FRAME_DIV,
  parameter int PPM_LIMIT   = `DSR_PPM_LIMIT,
  parameter int SEC_NOM     = `DSR_SEC_NOM_HZ * `DSR_MEAS_INTERVAL_S
) (
  input  wire logic                i_clk,
  input  wire logic                i_reset_n,
  input  wire logic                i_pin_strap_control_select,
  input  wire logic                i_fast_acquire_select,
  input  wire logic                i_data_strobe_n,
  input  wire logic                i_host_rate_sel_t3,
  input  wire logic                i_host_rate_divide_select,
  input  wire logic                i_strap_rate_sel_t3,
  input  wire logic                i_strap_rate_divide_select,
  input  wire logic                i_phase_continuity_ctrl_in,
  input  wire logic                i_sec_ref,
  input  wire dsr_pkg::dsr_mode_t  i_mode,
  input  wire dsr_pkg::dsr_ref_t   i_ref_sel,
  input  wire logic                i_freq_locked,
  output logic                     o_e3_t3_rate_clock_out,
  output logic                     o_frame_pulse_8k_out,
  output logic                     o_holdover,
  output logic                     o_lock,
  output logic                     o_fast_lock_active,
  output logic                     o_phase_continuity_captured,
  output logic                     o_pri_hold_to_pri_norm_ok,
  output logic                     o_pri_hold_to_sec_norm_ok,
  output logic                     o_secondary_ref_out_of_range,
  output logic                     o_host_access
);
  import dsr_pkg::*;

  localparam int STEP_W = 24;
  localparam logic [STEP_W-1:0] STEP_E3 =
    STEP_W'((64'(`DSR_E3_KHZ) * 2 * (64'h1 << STEP_W)) / (`DSR_CLK_HZ / 1000));
  localparam logic [STEP_W-1:0] STEP_T3 =
    STEP_W'((64'(`DSR_T3_KHZ) * 2 * (64'h1 << STEP_W)) / (`DSR_CLK_HZ / 1000));
  localparam int LIM = (SEC_NOM * PPM_LIMIT) / 1000000;

  if (MEAS_CYCLES < 2 || FRAME_DIV < 2) begin : g_bad_counts
    $error("dsr_status: counts too small");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
  } dsr_sync_t;

  // ------------------------------------------------------------
  // block state
  // ------------------------------------------------------------
  typedef struct packed {
    dsr_sync_t  sy;
    logic       sec_d;
    logic [31:0] meas_cnt;
    logic [31:0] edge_cnt;
    logic [31:0] frame_cnt;
    logic       frame;
    logic       pcc_cap;
    logic       holdover;
    logic       lock;
    logic       fast;
    logic       oor;
    logic       ds_d;
    logic       host_access;
    logic       rate_q;
  } dsr_state_t;

  dsr_state_t st_r;
  dsr_state_t st_nxt;
  logic       sel_t3;
  logic       sel_full;
  logic       rate_clk;

  function automatic logic over_limit(input logic [31:0] cnt);
    logic [31:0] dev;
    dev = (cnt > 32'(SEC_NOM)) ? cnt - 32'(SEC_NOM) : 32'(SEC_NOM) - cnt;
    return dev > 32'(LIM);
  endfunction

  always_comb begin
    logic hw;
    logic pcc;
    logic sec;
    logic ds_n;
    logic fl;
    logic [31:0] edge_now;
    hw   = st_r.sy.s2[0];
    fl   = st_r.sy.s2[1];
    ds_n = st_r.sy.s2[2];
    pcc  = st_r.sy.s2[7];
    sec  = st_r.sy.s2[8];
    edge_now = st_r.edge_cnt + {31'h0, sec && !st_r.sec_d};
    st_nxt = st_r;
    st_nxt.rate_q = rate_clk;
    st_nxt.sy.s1 = {i_sec_ref, i_phase_continuity_ctrl_in, i_strap_rate_divide_select,
                    i_strap_rate_sel_t3, i_host_rate_divide_select, i_host_rate_sel_t3,
                    i_data_strobe_n, i_fast_acquire_select, i_pin_strap_control_select};
    st_nxt.sy.s2 = st_r.sy.s1;

    if (st_r.frame_cnt >= 32'(FRAME_DIV - 1)) begin
      st_nxt.frame_cnt = '0;
    end else begin
      st_nxt.frame_cnt = st_r.frame_cnt + 32'h1;
    end
    st_nxt.frame = st_r.frame_cnt < 32'(FRAME_DIV / 2);

    if (st_nxt.frame && !st_r.frame) begin
      st_nxt.pcc_cap = pcc;
    end

    st_nxt.holdover = (i_mode == DSR_HOLDOVER);
    st_nxt.lock = i_freq_locked && (i_mode == DSR_NORMAL);
    st_nxt.fast = hw && fl;

    st_nxt.ds_d = ds_n;
    st_nxt.host_access = !hw && !ds_n && st_r.ds_d;

    st_nxt.sec_d = sec;
    st_nxt.edge_cnt = edge_now;
    if (st_r.meas_cnt >= 32'(MEAS_CYCLES - 1)) begin
      st_nxt.meas_cnt = '0;
      st_nxt.edge_cnt = '0;
      st_nxt.oor = over_limit(edge_now);
    end else begin
      st_nxt.meas_cnt = st_r.meas_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sel_t3   = st_r.sy.s2[0] ? st_r.sy.s2[5] : st_r.sy.s2[3];
  assign sel_full = st_r.sy.s2[0] ? st_r.sy.s2[6] : st_r.sy.s2[4];

  dsr_rate_gen #(
    .ACC_W (STEP_W)
  ) u_rate (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_step    (sel_t3 ? STEP_T3 : STEP_E3),
    .i_div4    (!sel_full),
    .o_clk_out (rate_clk)
  );

  assign o_e3_t3_rate_clock_out       = st_r.rate_q;
  assign o_frame_pulse_8k_out         = st_r.frame;
  assign o_holdover                   = st_r.holdover;
  assign o_lock                       = st_r.lock;
  assign o_fast_lock_active           = st_r.fast;
  assign o_phase_continuity_captured  = st_r.pcc_cap;
  assign o_pri_hold_to_pri_norm_ok    = st_r.pcc_cap;
  assign o_pri_hold_to_sec_norm_ok    = st_r.pcc_cap;
  assign o_secondary_ref_out_of_range = st_r.oor;
  assign o_host_access                = st_r.host_access;
endmodule // dsr_status

// File: testbench/dsr_ref_model.sv
// --
// secondary reference source
// --
module dsr_ref_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_period,
  output logic            o_ref
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r = 8'h00;
  always @(negedge i_clk) begin
    cnt_r <= (cnt_r + 8'h01 >= i_period) ? 8'h00 : cnt_r + 8'h01;
    o_ref <= cnt_r == 8'h00;
  end
endmodule // dsr_ref_model

// File: testbench/dsr_status_checker.sv
// --
// status checker
// --
module dsr_status_checker (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pin_strap_control_select,
  input wire logic i_fast_acquire_select,
  input wire dsr_pkg::dsr_mode_t i_mode,
  input wire logic i_freq_locked,
  input wire logic o_frame_pulse_8k_out,
  input wire logic o_holdover,
  input wire logic o_lock,
  input wire logic o_fast_lock_active,
  input wire logic o_phase_continuity_captured,
  input wire logic o_pri_hold_to_pri_norm_ok,
  input wire logic o_pri_hold_to_sec_norm_ok,
  input wire logic o_secondary_ref_out_of_range,
  input wire logic o_host_access
);
  timeunit 1ns;
  timeprecision 1ps;
  import dsr_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_holdover_level: assert property (o_holdover == $past(i_mode == DSR_HOLDOVER))
    else $error("holdover");
  a_lock_level: assert property (o_lock == $past(i_freq_locked && i_mode == DSR_NORMAL))
    else $error("lock");
  a_capture_on_frame: assert property (
    $changed(o_phase_continuity_captured) |-> $rose(o_frame_pulse_8k_out)
    || ($past(o_frame_pulse_8k_out) && !$past(o_frame_pulse_8k_out, 2))) else $error("capture");
  a_enables_follow: assert property (o_pri_hold_to_pri_norm_ok == o_phase_continuity_captured
    && o_pri_hold_to_sec_norm_ok == o_phase_continuity_captured) else $error("enables");
  a_fast_ignored: assert property ((!i_pin_strap_control_select)[*4] |-> !o_fast_lock_active)
    else $error("fast off");
  a_fast_strap: assert property (
    (i_pin_strap_control_select && i_fast_acquire_select)[*4] |-> o_fast_lock_active)
    else $error("fast on");
  a_host_pulse: assert property (o_host_access |=> !o_host_access) else $error("pulse");
  a_oor_hold: assert property (
    $changed(o_secondary_ref_out_of_range) |=> $stable(o_secondary_ref_out_of_range)[*8])
    else $error("oor");
  cover property (o_holdover);
  cover property (o_host_access);
  cover property ($rose(o_secondary_ref_out_of_range));
endmodule // dsr_status_checker
bind dsr_status dsr_status_checker i_dsr_status_checker (.*);

// File: testbench/dsr_status_test.sv
// --
// status bench
// --
module dsr_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dsr_pkg::*;
  logic i_clk = 0, i_reset_n = 0, i_pin_strap_control_select = 0, i_fast_acquire_select = 0;
  logic i_data_strobe_n = 1, i_host_rate_sel_t3 = 0, i_host_rate_divide_select = 1;
  logic i_strap_rate_sel_t3 = 1, i_strap_rate_divide_select = 1, i_phase_continuity_ctrl_in = 0;
  logic i_sec_ref, i_freq_locked = 0, o_e3_t3_rate_clock_out, o_frame_pulse_8k_out, o_holdover;
  logic o_lock, o_fast_lock_active, o_phase_continuity_captured, o_pri_hold_to_pri_norm_ok;
  logic o_pri_hold_to_sec_norm_ok, o_secondary_ref_out_of_range, o_host_access;
  logic [7:0] period = 8'h14;
  dsr_mode_t i_mode = DSR_FREE_RUN;
  dsr_ref_t i_ref_sel = DSR_REF_SEC;
  int fails = 0, tests_run = 0, cyc = 0, pulses = 0, rises = 0, n;
  always #2 i_clk = ~i_clk;
  always @(posedge o_e3_t3_rate_clock_out) rises++;
  always @(posedge i_clk) begin
    cyc++;
    if (o_host_access === 1'b1) pulses++;
    if (cyc == 40000) begin
      fails++;
      stop_test();
    end
  end
  dsr_status #(.MEAS_CYCLES(2000), .FRAME_DIV(25), .SEC_NOM(100)) i_dsr_status (.*);
  dsr_ref_model i_dsr_ref_model (.i_clk(i_clk), .i_period(period), .o_ref(i_sec_ref));
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic step(int k);
    repeat (k) @(negedge i_clk);
  endtask
  task automatic strobe();
    step(5);
    i_data_strobe_n = 0;
    step(3);
    i_data_strobe_n = 1;
    step(6);
  endtask
  task automatic rate(int e);
    step(10);
    n = rises;
    step(1000);
    chk((rises - n - e) inside {[-2:2]}, 1);
  endtask
  task automatic stop_test();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    step(3);
    i_reset_n = 1;
    i_mode = DSR_HOLDOVER;
    step(3);
    chk({o_holdover, o_lock}, 2'h2);
    i_mode = DSR_NORMAL;
    i_freq_locked = 1;
    step(2);
    chk({o_holdover, o_lock}, 2'h1);
    i_freq_locked = 0;
    i_fast_acquire_select = 1;
    strobe();
    chk({o_lock, o_fast_lock_active, pulses[1:0]}, 4'h1);
    i_pin_strap_control_select = 1;
    strobe();
    chk({o_fast_lock_active, pulses[1:0]}, 3'h5);
    rate(178);
    i_strap_rate_divide_select = 0;
    rate(44);
    i_pin_strap_control_select = 0;
    rate(137);
    @(posedge o_frame_pulse_8k_out);
    step(1);
    i_phase_continuity_ctrl_in = 1;
    step(6);
    chk(o_phase_continuity_captured, 0);
    @(posedge o_frame_pulse_8k_out);
    step(3);
    chk({o_phase_continuity_captured, o_pri_hold_to_pri_norm_ok, o_pri_hold_to_sec_norm_ok}, 3'h7);
    @(posedge o_frame_pulse_8k_out);
    n = cyc;
    @(posedge o_frame_pulse_8k_out);
    chk(cyc - n, 25);
    step(4200);
    chk(o_secondary_ref_out_of_range, 0);
    period = 8'h19;
    step(4200);
    chk(o_secondary_ref_out_of_range, 1);
    stop_test();
  end
endmodule // dsr_status_test
